// >>> src/acc_analog_comparator_ctrl.sv
// Digital control around the analog comparator with Avalon-MM registers and power modes.
// Summary of operation
// RULE1: Routing bit feeds result to timer capture zero.
// RULE2: Routing bit disconnects timer channel zero pin.
// RULE3: Software sets reference buffer when selecting reference.
// RULE4: Comparator keeps detecting events during wait mode.
// RULE5: Enabled event in wait raises interrupt request.
// RULE6: Software disables comparator in wait if unused.
// RULE7: Shallowest stop keeps comparing without bus clock.
// RULE8: Shallowest stop keeps driving enabled output pin.
// RULE9: Shallowest stop event sets flag and wakes.
// RULE10: Reset exit from stop restores reset state.
// RULE11: Deeper stop modes power comparator fully down.
// RULE12: Wake from deeper stop presents reset state.
// RULE13: Background debug halt keeps comparator running normally.
// RULE14: Event selectable as rising, falling or both.
// RULE15: Mode 00 fall, 01 rise, 10 fall, 11 both.
// RULE16: Flag sets on event, cleared writing one.
// RULE17: Interrupt asserted while flag and enable set.
// RULE18: Live result bit reads zero when disabled.
// RULE19: Raw result synchronised by two flip-flops.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
module acc_analog_comparator_ctrl
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] power_mode,
  input wire logic comparator_raw,
  input wire logic timer_one_channel_zero_pin_in,
  output logic comparator_enable,
  output logic reference_select,
  output logic comparator_output_pin,
  output logic comparator_output_pin_oe,
  output logic timer_one_channel_zero_pin_oe_n,
  output logic timer_one_capture_in,
  output logic compare_irq,
  output logic stop_wakeup,
  output logic irq
);

  logic [7:0] ctrl_q;
  logic route_q;
  logic [ACC_IRQ_W-1:0] status_q;
  logic [ACC_IRQ_W-1:0] mask_q;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic prev_valid_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic deep_stop;
  logic active;
  logic rise;
  logic fall;
  logic event_hit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_accept;
  logic wr_route;
  logic wr_mask;
  logic access;
  logic [1:0] mode;
  acc_pmode_e pmode;

  assign pmode = acc_pmode_e'(power_mode);
  // Deeper stop modes hold control, status and routing in reset so waking shows reset state; the mask keeps its value.
  assign deep_stop = (pmode == ACC_PM_STOP2) || (pmode == ACC_PM_STOP1); // RULE11 RULE12
  // Run, wait, stop3 and debug halt all keep the comparator working alike.
  assign active = ctrl_q[ACC_ENABLE_BIT] && !deep_stop; // RULE4 RULE7 RULE13
  assign mode = ctrl_q[ACC_MODE_LO_BIT+1:ACC_MODE_LO_BIT];

  // Two-stage synchroniser on the asynchronous comparator result.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= comparator_raw; // RULE19
      sync2_q <= sync1_q;
    end
  end

  // Previous synchronised value; invalid right after enabling so no false edge.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
      prev_valid_q <= 1'b0;
    end else begin
      prev_q <= sync2_q;
      prev_valid_q <= active;
    end
  end

  assign rise = active && prev_valid_q && sync2_q && !prev_q;
  assign fall = active && prev_valid_q && !sync2_q && prev_q;

  // Event selection by mode field.
  always_comb begin
    case (mode) // RULE14 RULE15
      ACC_MODE_RISE: event_hit = rise;
      ACC_MODE_BOTH: event_hit = rise || fall;
      ACC_MODE_FALL0: event_hit = fall;
      ACC_MODE_FALL2: event_hit = fall;
      default: event_hit = 1'b0;
    endcase
  end

  // Bus access decode; every access is answered one cycle after it is seen.
  // A write lands only at the edge where waitrequest is low, where the master completes it.
  assign access = (avs_read || avs_write) && !ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_accept = avs_write && ack_q && avs_byteenable[0];
  assign wr_ctrl = wr_accept && (avs_address == ACC_CTRL_OFS);
  assign wr_stat = wr_accept && (avs_address == ACC_IRQ_STATUS_OFS);
  assign wr_route = wr_accept && (avs_address == ACC_SYSOPT_OFS);
  assign wr_mask = wr_accept && (avs_address == ACC_IRQ_MASK_OFS);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // Control bits; the flag and live bits are kept apart in their own logic.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= ACC_CTRL_RST; // RULE10
    end else if (deep_stop) begin
      ctrl_q <= ACC_CTRL_RST; // RULE11 RULE12
    end else begin
      if (wr_ctrl) begin
        ctrl_q[ACC_ENABLE_BIT] <= avs_writedata[ACC_ENABLE_BIT];
        ctrl_q[ACC_REFSEL_BIT] <= avs_writedata[ACC_REFSEL_BIT];
        ctrl_q[ACC_IE_BIT] <= avs_writedata[ACC_IE_BIT];
        ctrl_q[ACC_OPE_BIT] <= avs_writedata[ACC_OPE_BIT];
        ctrl_q[ACC_MODE_LO_BIT+1:ACC_MODE_LO_BIT] <=
          avs_writedata[ACC_MODE_LO_BIT+1:ACC_MODE_LO_BIT];
      end
      // Event wins over a simultaneous write-one clear.
      if (event_hit) begin
        ctrl_q[ACC_FLAG_BIT] <= 1'b1; // RULE16
      end else if (wr_ctrl && avs_writedata[ACC_FLAG_BIT]) begin
        ctrl_q[ACC_FLAG_BIT] <= 1'b0; // RULE16
      end
      ctrl_q[ACC_LIVE_BIT] <= 1'b0;
    end
  end

  // Timer routing option, also cleared by deep stop.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      route_q <= ACC_ROUTE_RST;
    end else if (deep_stop) begin
      route_q <= ACC_ROUTE_RST;
    end else if (wr_route) begin
      route_q <= avs_writedata[ACC_ROUTE_BIT];
    end
  end

  // Sticky interrupt status; set wins over write-one-to-clear.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= ACC_IRQ_RST;
    end else if (deep_stop) begin
      status_q <= ACC_IRQ_RST;
    end else begin
      if (event_hit) begin
        status_q[ACC_EVT_BIT] <= 1'b1;
      end else if (wr_stat && avs_writedata[ACC_EVT_BIT]) begin
        status_q[ACC_EVT_BIT] <= 1'b0;
      end
      if (stop_wakeup) begin
        status_q[ACC_WAKE_BIT] <= 1'b1;
      end else if (wr_stat && avs_writedata[ACC_WAKE_BIT]) begin
        status_q[ACC_WAKE_BIT] <= 1'b0;
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= ACC_IRQ_RST;
    end else if (wr_mask) begin
      mask_q <= avs_writedata[ACC_IRQ_W-1:0];
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        ACC_CTRL_OFS: begin
          rdata_q <= {24'h000000, ctrl_q[7:4], active && sync2_q, ctrl_q[2:0]}; // RULE18
        end
        ACC_IRQ_STATUS_OFS: rdata_q <= {30'h0000_0000, status_q};
        ACC_IRQ_MASK_OFS: rdata_q <= {30'h0000_0000, mask_q};
        ACC_SYSOPT_OFS: rdata_q <= {31'h0000_0000, route_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // Interrupt and wakeup requests toward the CPU and mode controller.
  assign compare_irq = ctrl_q[ACC_FLAG_BIT] && ctrl_q[ACC_IE_BIT]; // RULE17 RULE5
  assign stop_wakeup = (pmode == ACC_PM_STOP3) && compare_irq; // RULE9
  assign irq = |(status_q & mask_q);

  // Output pin follows the synchronised result in every working mode.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      comparator_output_pin <= 1'b0;
      comparator_output_pin_oe <= 1'b0;
    end else begin
      comparator_output_pin <= active && sync2_q; // RULE8
      comparator_output_pin_oe <= active && ctrl_q[ACC_OPE_BIT]; // RULE8
    end
  end

  // Timer capture routing: result replaces the pin and the pin is cut off.
  assign timer_one_capture_in = route_q ? (active && sync2_q) : timer_one_channel_zero_pin_in; // RULE1
  assign timer_one_channel_zero_pin_oe_n = route_q; // RULE2

  // Analog core enable; the reference buffer itself is software's job.
  assign comparator_enable = active; // RULE11
  assign reference_select = ctrl_q[ACC_REFSEL_BIT]; // RULE3

  // Checks on event detection and the event flag.
  a_flag_set_event: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
    event_hit && !deep_stop |=> ctrl_q[ACC_FLAG_BIT])
    else $error("Flag not set after event.");

  a_flag_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
    ctrl_q[ACC_FLAG_BIT] && !deep_stop && !(wr_ctrl && avs_writedata[ACC_FLAG_BIT])
    |=> ctrl_q[ACC_FLAG_BIT])
    else $error("Flag lost without clear.");

  a_stat_set: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
    event_hit |=> status_q[ACC_EVT_BIT])
    else $error("Status bit not set after event.");

  a_irq_follow_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE17
    compare_irq == (ctrl_q[ACC_FLAG_BIT] && ctrl_q[ACC_IE_BIT]))
    else $error("Interrupt does not follow flag and enable.");

  a_rise_mode: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
    mode == ACC_MODE_RISE && fall |-> !event_hit)
    else $error("Falling edge hit in rising mode.");

  a_fall_mode: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE14
    !mode[0] && rise |-> !event_hit)
    else $error("Rising edge hit in falling mode.");

  a_rise_hit: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE14
    mode == ACC_MODE_RISE && rise |-> event_hit)
    else $error("Rising edge missed in rising mode.");

  a_fall_hit: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
    !mode[0] && fall |-> event_hit)
    else $error("Falling edge missed in falling mode.");

  a_both_hit: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
    mode == ACC_MODE_BOTH && (rise || fall) |-> event_hit)
    else $error("Edge missed in either-edge mode.");

  a_first_edge: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE19
    active && !$past(active) |-> !event_hit)
    else $error("Event taken in the first enabled cycle.");

  a_sync_delay: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE19
    $rose(sync2_q) |-> $past(comparator_raw, 2))
    else $error("Synchroniser depth wrong.");

  // Checks on power modes.
  a_wait_run: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE4
    pmode == ACC_PM_WAIT && ctrl_q[ACC_ENABLE_BIT] |-> comparator_enable)
    else $error("Comparator stopped in wait mode.");

  a_wait_irq: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
    pmode == ACC_PM_WAIT && event_hit && ctrl_q[ACC_IE_BIT] |=> compare_irq)
    else $error("No interrupt after wait mode event.");

  a_stop3_wake: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
    pmode == ACC_PM_STOP3 && event_hit && ctrl_q[ACC_IE_BIT] |=> stop_wakeup)
    else $error("No wakeup after stop3 event.");

  a_wake_stop3: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
    stop_wakeup |-> pmode == ACC_PM_STOP3 && compare_irq)
    else $error("Wakeup outside stop3 or without interrupt.");

  a_debug_run: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE13
    pmode == ACC_PM_BDM && ctrl_q[ACC_ENABLE_BIT] |-> comparator_enable)
    else $error("Comparator stopped in debug halt.");

  a_deep_reset: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE11
    deep_stop |=> ctrl_q == ACC_CTRL_RST && !comparator_output_pin_oe)
    else $error("Deep stop did not clear the comparator.");

  a_deep_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE12
    deep_stop |=> status_q == ACC_IRQ_RST && route_q == ACC_ROUTE_RST)
    else $error("Deep stop left status or routing set.");

  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE11
    !active |=> !comparator_output_pin_oe && !comparator_output_pin)
    else $error("Output pin driven while inactive.");

  // Checks on pins, routing and the register bus.
  a_pin_drive: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE8
    active && ctrl_q[ACC_OPE_BIT]
    |=> comparator_output_pin_oe && (comparator_output_pin == $past(sync2_q)))
    else $error("Output pin does not follow the result.");

  a_live_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE18
    avs_read && !ack_q && avs_address == ACC_CTRL_OFS && !active
    |=> !avs_readdata[ACC_LIVE_BIT])
    else $error("Live bit nonzero while disabled.");

  a_route_cut: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE1
    route_q
    |-> timer_one_channel_zero_pin_oe_n && timer_one_capture_in == (active && sync2_q))
    else $error("Timer routing wrong.");

  a_route_pin: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE2
    !route_q |-> !timer_one_channel_zero_pin_oe_n && timer_one_capture_in == timer_one_channel_zero_pin_in)
    else $error("Timer pin not passed through.");

  a_one_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("More than one wait state.");

endmodule : acc_analog_comparator_ctrl

// >>> src/acc_pkg.sv
// Package with register map, field layout and reset values of the comparator control block.
package acc_pkg;

  // Register word offsets (byte addresses on the Avalon-MM bus).
  localparam logic [3:0] ACC_CTRL_OFS = 4'h0;
  localparam logic [3:0] ACC_IRQ_STATUS_OFS = 4'h4;
  localparam logic [3:0] ACC_IRQ_MASK_OFS = 4'h8;
  localparam logic [3:0] ACC_SYSOPT_OFS = 4'hC;

  // Control and status register field positions.
  localparam int ACC_MODE_LO_BIT = 0;
  localparam int ACC_OPE_BIT = 2;
  localparam int ACC_LIVE_BIT = 3;
  localparam int ACC_IE_BIT = 4;
  localparam int ACC_FLAG_BIT = 5;
  localparam int ACC_REFSEL_BIT = 6;
  localparam int ACC_ENABLE_BIT = 7;

  // Sticky status bits: compare event and wakeup request.
  localparam int ACC_EVT_BIT = 0;
  localparam int ACC_WAKE_BIT = 1;
  localparam int ACC_IRQ_W = 2;

  // System option bit that routes the result to timer one channel zero.
  localparam int ACC_ROUTE_BIT = 0;

  // Reset values.
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [1:0] ACC_IRQ_RST = 2'h0;
  localparam logic ACC_ROUTE_RST = 1'b0;

  // Event mode encodings.
  localparam logic [1:0] ACC_MODE_FALL0 = 2'h0;
  localparam logic [1:0] ACC_MODE_RISE = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL2 = 2'h2;
  localparam logic [1:0] ACC_MODE_BOTH = 2'h3;

  // Power modes reported by the system mode controller.
  typedef enum logic [2:0] {
    ACC_PM_RUN,
    ACC_PM_WAIT,
    ACC_PM_STOP3,
    ACC_PM_STOP2,
    ACC_PM_STOP1,
    ACC_PM_BDM
  } acc_pmode_e;

endpackage : acc_pkg

// >>> tb/acc_comparator_model.sv
// Behavioural model of the analog comparator core beside the control block.
module acc_comparator_model (
  input wire logic core_clk,
  input wire logic comparator_enable,
  input wire logic reference_select,
  input wire logic level,
  output logic comparator_raw,
  output logic reference_buffer_enable
);
  timeunit 1ns;
  timeprecision 1ns;

  // The buffer follows the reference choice, so the reference input is always valid.
  assign reference_buffer_enable = reference_select;

  // A powered-down core holds its output low, like the live bit of a disabled block.
  always @(posedge core_clk) begin
    if (comparator_enable) begin
      comparator_raw <= level;
    end else begin
      comparator_raw <= 1'b0;
    end
  end

  initial comparator_raw = 1'b0;
endmodule : acc_comparator_model

// >>> tb/acc_analog_comparator_ctrl_test.sv
// Self-checking bench for the comparator control block and its register interface.
module acc_analog_comparator_ctrl_test;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd_q;
  logic avs_waitrequest, comparator_raw, comparator_enable, reference_select, buf_en;
  logic [2:0] power_mode = 3'h0;
  logic level = 1'b0;
  logic pin_in = 1'b0;
  logic out_pin, out_oe, pin_oe_n, cap_in, compare_irq, stop_wakeup, irq, rise;
  logic [7:0] e;
  int n_mismatch = 0;
  int n_tests = 0;

  always #20 core_clk = ~core_clk;

  acc_analog_comparator_ctrl i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_mode(power_mode),
    .comparator_raw(comparator_raw), .timer_one_channel_zero_pin_in(pin_in),
    .comparator_enable(comparator_enable), .reference_select(reference_select),
    .comparator_output_pin(out_pin), .comparator_output_pin_oe(out_oe),
    .timer_one_channel_zero_pin_oe_n(pin_oe_n), .timer_one_capture_in(cap_in),
    .compare_irq(compare_irq), .stop_wakeup(stop_wakeup), .irq(irq));

  acc_comparator_model i_core (.core_clk(core_clk), .comparator_enable(comparator_enable),
    .reference_select(reference_select), .level(level), .comparator_raw(comparator_raw),
    .reference_buffer_enable(buf_en));

  // One Avalon transfer; waitrequest and read data are taken at the rising edge.
  // Only the watchdog ends a wait that never completes.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask : bus

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    check("readdata", rd_q, {24'h0, x});
  endtask : rd_chk

  // Moves the analog result and allows for the core, the two-stage sync and the flag.
  task automatic lvl(input logic v);
    @(posedge core_clk);
    level <= v;
    repeat (5) @(posedge core_clk);
    #1;
  endtask : lvl

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // The whole run needs well under a thousand cycles; this bound is generous.
  initial begin
    #100us;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i += 2) rd_chk(4'(i), 8'h00);
    bus(1'b1, ACC_CTRL_OFS, 8'h80);
    lvl(1'b0);
    // Every event mode sees one rise and one fall.
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ACC_CTRL_OFS, 8'hB0 | 8'(m));
      lvl(1'b1);
      rise = (m == 1 || m == 3);
      check("compare_irq", 32'(compare_irq), 32'(rise));
      e = 8'h98 | 8'(m) | (rise ? 8'h20 : 8'h00);
      rd_chk(ACC_CTRL_OFS, e);
      bus(1'b1, ACC_CTRL_OFS, 8'hB0 | 8'(m));
      lvl(1'b0);
      e = 8'h90 | 8'(m) | ((m != 1) ? 8'h20 : 8'h00);
      rd_chk(ACC_CTRL_OFS, e);
    end
    bus(1'b1, ACC_CTRL_OFS, 8'hB7);
    rd_chk(ACC_CTRL_OFS, 8'h97);
    bus(1'b1, ACC_IRQ_MASK_OFS, 8'h01);
    check("irq", 32'(irq), 32'h1);
    bus(1'b1, ACC_IRQ_STATUS_OFS, 8'h01);
    check("irq", 32'(irq), 32'h0);
    @(posedge core_clk) power_mode <= 3'h1;
    lvl(1'b1);
    check("compare_irq", 32'(compare_irq), 32'h1);
    check("output_pin", 32'(out_pin), 32'h1);
    bus(1'b1, ACC_CTRL_OFS, 8'hB7);
    @(posedge core_clk) power_mode <= 3'h2;
    lvl(1'b0);
    check("stop_wakeup", 32'(stop_wakeup), 32'h1);
    rd_chk(ACC_IRQ_STATUS_OFS, 8'h03);
    lvl(1'b1);
    check("output_pin", 32'(out_pin), 32'h1);
    check("output_pin_oe", 32'(out_oe), 32'h1);
    bus(1'b1, ACC_CTRL_OFS, 8'hB7);
    @(posedge core_clk) power_mode <= 3'h5;
    lvl(1'b0);
    check("compare_irq", 32'(compare_irq), 32'h1);
    @(posedge core_clk) power_mode <= 3'h0;
    pin_in <= 1'b1;
    bus(1'b1, ACC_SYSOPT_OFS, 8'h01);
    check("pin_oe_n", 32'(pin_oe_n), 32'h1);
    check("capture_in", 32'(cap_in), 32'h0);
    bus(1'b1, ACC_SYSOPT_OFS, 8'h00);
    check("capture_in", 32'(cap_in), 32'h1);
    // Both deep stop modes power the comparator off and leave it reset.
    for (int p = 3; p < 5; p++) begin
      bus(1'b1, ACC_CTRL_OFS, 8'hB7);
      bus(1'b1, ACC_SYSOPT_OFS, 8'h01);
      @(posedge core_clk) power_mode <= 3'(p);
      lvl(~level);
      check("enable", 32'(comparator_enable), 32'h0);
      check("compare_irq", 32'(compare_irq), 32'h0);
      check("output_pin_oe", 32'(out_oe), 32'h0);
      @(posedge core_clk) power_mode <= 3'h0;
      rd_chk(ACC_CTRL_OFS, 8'h00);
      rd_chk(ACC_SYSOPT_OFS, 8'h00);
    end
    // Software picks the reference with the core off and parks it before waiting.
    bus(1'b1, ACC_CTRL_OFS, 8'h40);
    check("reference_select", 32'(reference_select), 32'h1);
    check("buffer_enable", 32'(buf_en), 32'h1);
    @(posedge core_clk) power_mode <= 3'h1;
    #1;
    check("enable", 32'(comparator_enable), 32'h0);
    bus(1'b1, ACC_CTRL_OFS, 8'h97);
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk(ACC_CTRL_OFS, 8'h00);
    results();
  end
endmodule : acc_analog_comparator_ctrl_test
